// *** dv/prog_data_side_model.sv ***
// far-side model: register read data and password words in program memory
`timescale 1ns/1ps
`default_nettype none
module prog_data_side_model (
  input wire logic sys_clk,
  input wire logic [15:0] instr,
  input wire logic [3:0] pw_word_addr,
  input wire logic pw_erase_fill,
  output logic [15:0] src_reg_data,
  output logic [15:0] pw_stored
);
  logic [15:0] pw_mem [16'h0010:16'h001F];

  ////////////////////////////////////////////////////////////////////////////
  // distinct bytes, so a swapped nibble or byte in decode shows up
  assign src_reg_data = {instr[7:0], ~instr[7:0]};
  assign pw_stored = pw_mem[16'h0010 + {12'h000, pw_word_addr}];

  ////////////////////////////////////////////////////////////////////////////
  // flash survives reset, so the key is loaded once at time zero
  initial
  begin
    for (int a = 16'h0010; a <= 16'h001F; a++)
      pw_mem[a] = 16'h5A00 + 16'(a);
  end

  always @(posedge sys_clk)
  begin
    if (pw_erase_fill)
      for (int a = 16'h0010; a <= 16'h001F; a++)
        pw_mem[a] <= 16'hFFFF;
  end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the core decode and stack block
`timescale 1ns/1ps
`default_nettype none
`include "risc_core_consts.svh"
module tb_top;
  typedef struct packed {
    logic [15:0] w;
    logic imm;
    logic [3:0] sm;
    logic [3:0] si;
    logic [3:0] dm;
    logic [7:0] di;
    logic [15:0] md;
  } row_type;
  row_type rows [5] = '{
    '{16'h0312, 1'b1, 4'h0, 4'h0, 4'h3, 8'h00, 16'h0012},
    '{16'h7201, 1'b1, 4'h0, 4'h0, 4'h2, 8'h07, 16'h0001},
    '{16'h93A7, 1'b0, 4'h7, 4'hA, 4'h3, 8'h01, 16'hA758},
    '{16'hE4FF, 1'b0, 4'hF, 4'hF, 4'h4, 8'h06, 16'hFF00},
    '{16'h0500, 1'b1, 4'h0, 4'h0, 4'h5, 8'h00, 16'h0000}
  };
  logic sys_clk, rst_n, clk_en, instr_valid, int_request, watchdog_reset;
  logic [15:0] instr, src_reg_data, int_vector, pw_attempt, pw_stored;
  logic pw_attempt_valid, flash_write_req, mass_erase_req, lock_set_req;
  logic exec_from_data, const_from_prog;
  logic [15:0] prog_addr, move_data, acc_value, dp0, dp1, dp2, stack_top;
  logic prog_in_rom, prog_in_data, src_is_imm, dst_write, data_from_prog;
  logic [3:0] src_module, src_index, dst_module, stack_index, pw_word_addr;
  logic [7:0] dst_index;
  logic password_lock_bit, flash_write_grant, flash_write_refused;
  logic pw_erase_fill;
  logic [15:0] p_before;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  risc_core_decode_stack u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .instr(instr), .instr_valid(instr_valid),
    .src_reg_data(src_reg_data), .int_request(int_request),
    .int_vector(int_vector), .watchdog_reset(watchdog_reset),
    .pw_attempt(pw_attempt), .pw_attempt_valid(pw_attempt_valid),
    .pw_stored(pw_stored), .flash_write_req(flash_write_req),
    .mass_erase_req(mass_erase_req), .lock_set_req(lock_set_req),
    .exec_from_data(exec_from_data), .const_from_prog(const_from_prog),
    .prog_addr(prog_addr), .prog_in_rom(prog_in_rom),
    .prog_in_data(prog_in_data), .src_module(src_module),
    .src_index(src_index), .src_is_imm(src_is_imm),
    .dst_module(dst_module), .dst_index(dst_index), .dst_write(dst_write),
    .move_data(move_data), .acc_value(acc_value), .dp0(dp0), .dp1(dp1),
    .dp2(dp2), .data_from_prog(data_from_prog), .stack_index(stack_index),
    .stack_top(stack_top), .password_lock_bit(password_lock_bit),
    .flash_write_grant(flash_write_grant),
    .flash_write_refused(flash_write_refused),
    .pw_word_addr(pw_word_addr), .pw_erase_fill(pw_erase_fill));

  prog_data_side_model u_far (.sys_clk(sys_clk), .instr(instr),
    .pw_word_addr(pw_word_addr), .pw_erase_fill(pw_erase_fill),
    .src_reg_data(src_reg_data), .pw_stored(pw_stored));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // budget: roughly 100 cycles of tests, generous margin
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      $display("Error at %0t: run did not finish in time", $time);
      close_out();
    end
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // valid is held across back-to-back words, dropped only by idle
  task automatic issue(input logic [15:0] w);
    instr = w;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    #10;
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(posedge sys_clk);
    #10;
  endtask

  task automatic flash_try(input logic grant);
    flash_write_req = 1'b1;
    @(posedge sys_clk);
    #10;
    flash_write_req = 1'b0;
    chk_bit(flash_write_grant, grant);
    chk_bit(flash_write_refused, !grant);
    idle();
    chk_bit(flash_write_grant | flash_write_refused, 1'b0);
  endtask

  task automatic send_key(input logic [15:0] base, input logic [15:0] step,
    input int bad);
    for (int i = 0; i < 16; i++)
    begin
      pw_attempt = (i == bad) ? 16'h0000 : base + step * 16'(i);
      pw_attempt_valid = 1'b1;
      @(posedge sys_clk);
      #10;
    end
    pw_attempt_valid = 1'b0;
    repeat (2) idle();
  endtask

  task automatic pulse_lock();
    lock_set_req = 1'b1;
    idle();
    lock_set_req = 1'b0;
    chk_bit(password_lock_bit, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk_en, instr_valid, int_request, watchdog_reset, rst_n} = 5'b10000;
    {pw_attempt_valid, flash_write_req, mass_erase_req} = 3'b000;
    {lock_set_req, exec_from_data, const_from_prog} = 3'b000;
    instr = 16'h0000;
    int_vector = 16'h0123;
    pw_attempt = 16'h0000;
    repeat (6) @(posedge sys_clk);
    #10;
    chk_val(prog_addr, `ROM_BASE);
    chk_bit(prog_in_rom, 1'b1);
    chk_val(16'(stack_index), 16'(`STACK_RESET));
    chk_bit(password_lock_bit, 1'b0);
    rst_n = 1'b1;
    foreach (rows[k])
    begin
      issue(rows[k].w);
      chk_val(move_data, rows[k].md);
      chk_bit(src_is_imm, rows[k].imm);
      chk_val(16'(dst_module), 16'(rows[k].dm));
      chk_val(16'(dst_index), 16'(rows[k].di));
      chk_bit(dst_write, 1'b1);
      if (!rows[k].imm)
      begin
        chk_val(16'(src_module), 16'(rows[k].sm));
        chk_val(16'(src_index), 16'(rows[k].si));
      end
    end
    chk_val(prog_addr, `ROM_BASE + 16'h0005);
    idle();
    chk_bit(dst_write, 1'b0);
    // prefix applies to the next word only
    issue(16'h0B03);
    issue(16'h4505);
    chk_val(16'(dst_index), 16'h001C);
    issue(16'h4505);
    chk_val(16'(dst_index), 16'h0004);
    // accumulator ops: load, add, sub, or, xor, and, register add
    issue(16'h0812);
    chk_val(acc_value, 16'h0012);
    issue(16'h1803);
    chk_val(acc_value, 16'h0015);
    issue(16'h2805);
    chk_val(acc_value, 16'h0010);
    issue(16'h4807);
    chk_val(acc_value, 16'h0017);
    issue(16'h5801);
    chk_val(acc_value, 16'h0016);
    issue(16'h3806);
    chk_val(acc_value, 16'h0006);
    issue(16'h9836);
    chk_val(acc_value, 16'h36CF);
    issue(16'h0A05);
    chk_val(acc_value, 16'h0000);
    issue(16'h0A00);
    chk_val(acc_value, 16'h36CF);
    // data pointers step up and down, dp1 wraps below zero
    issue(16'h0F00);
    chk_val(dp0, 16'h0001);
    issue(16'h0F01);
    chk_val(dp0, 16'h0000);
    issue(16'h1F01);
    chk_val(dp1, 16'hFFFF);
    issue(16'h2F00);
    chk_val(dp2, 16'h0001);
    // stack: push wraps F to 0, pop below 0 wraps to F
    issue(16'h0D11);
    chk_val(16'(stack_index), 16'h0000);
    issue(16'h0D22);
    chk_val(16'(stack_index), 16'h0001);
    issue(16'h1D00);
    chk_val(stack_top, 16'h0022);
    chk_val(16'(stack_index), 16'h0000);
    issue(16'h2D00);
    chk_val(stack_top, 16'h0011);
    chk_val(16'(stack_index), 16'h000F);
    issue(16'h1D00);
    chk_val(16'(stack_index), 16'h000E);
    issue(16'h0D33);
    issue(16'h1D00);
    chk_val(stack_top, 16'h0033);
    // call and return
    p_before = prog_addr;
    issue(16'h1C40);
    chk_val(prog_addr, 16'h0040);
    chk_val(16'(stack_index), 16'h000F);
    issue(16'h2C00);
    chk_val(prog_addr, p_before + 16'h0001);
    chk_val(16'(stack_index), 16'h000E);
    idle();
    // interrupt entry while no word is pending, then return from it
    p_before = prog_addr;
    int_request = 1'b1;
    idle();
    int_request = 1'b0;
    chk_val(prog_addr, 16'h0123);
    chk_val(16'(stack_index), 16'h000F);
    issue(16'h3C00);
    chk_val(prog_addr, p_before);
    chk_val(16'(stack_index), 16'h000E);
    issue(16'h0C00);
    chk_val(prog_addr, `APP_START);
    chk_bit(prog_in_rom, 1'b0);
    // frozen clock enable drops the word
    clk_en = 1'b0;
    issue(16'h0877);
    chk_val(acc_value, 16'h36CF);
    clk_en = 1'b1;
    watchdog_reset = 1'b1;
    idle();
    watchdog_reset = 1'b0;
    chk_val(prog_addr, `ROM_BASE);
    chk_bit(prog_in_rom, 1'b1);
    chk_val(16'(stack_index), 16'h000E);
    {exec_from_data, const_from_prog} = 2'b11;
    idle();
    chk_bit(prog_in_data, 1'b1);
    chk_bit(data_from_prog, 1'b1);
    {exec_from_data, const_from_prog} = 2'b00;
    // unprogrammed part accepts writes, locked part wants the key
    flash_try(1'b1);
    pulse_lock();
    flash_try(1'b0);
    send_key(16'h5A10, 16'h0001, 5);
    chk_val(16'(pw_word_addr), 16'h0000);
    flash_try(1'b0);
    mass_erase_req = 1'b1;
    idle();
    mass_erase_req = 1'b0;
    for (int n = 0; n < 3 && pw_erase_fill !== 1'b1; n++)
      idle();
    chk_bit(pw_erase_fill, 1'b1);
    chk_bit(password_lock_bit, 1'b0);
    repeat (2) idle();
    pulse_lock();
    // erased key is all ones in every word
    send_key(16'hFFFF, 16'h0000, 99);
    flash_try(1'b1);
    // second reset in mid-run
    rst_n = 1'b0;
    #100;
    chk_val(prog_addr, `ROM_BASE);
    chk_val(16'(stack_index), 16'(`STACK_RESET));
    @(posedge sys_clk);
    #10;
    rst_n = 1'b1;
    issue(16'h0312);
    chk_val(prog_addr, `ROM_BASE + 16'h0001);
    chk_bit(dst_write, 1'b1);
    chk_val(move_data, 16'h0012);
    idle();
    close_out();
  end
endmodule
`default_nettype wire

// *** logic/risc_core_consts.svh ***
// offsets, field positions, reset values and memory map constants for the core
`ifndef RISC_CORE_CONSTS_SVH
`define RISC_CORE_CONSTS_SVH
`define FMT_BIT 15
`define SRC_LSB 0
`define SRC_MSB 7
`define DST_LSB 8
`define DST_MSB 14
`define DST_MOD_W 4
`define DST_SUB_W 3
`define PFX_W 5
`define ROM_BASE 16'h8000
`define APP_START 16'h0000
`define PW_FIRST 16'h0010
`define PW_LAST 16'h001F
`define PW_WORDS 16
`define STACK_RESET 4'hF
`define STACK_DEPTH 16
`define FLASH_WORDS 32768
`define SRAM_WORDS 1024
`define ROM_WORDS 4096
`define NUM_ACC 16
`define NUM_DP 3
// module selectors of the special registers that carry side effects
`define MOD_ACC 4'h8
`define MOD_PFX 4'hB
`define MOD_SP 4'hD
`define MOD_SC 4'h8
`define MOD_DP 4'hF
`define MOD_IMM_ACC 4'hA
`define MOD_PC 4'hC
`endif

// *** logic/risc_core_decode_stack.sv ***
// instruction decode, prefix, accumulators, pointers, stack and password lock
`timescale 1ns/1ps
`default_nettype none
`include "risc_core_consts.svh"

////////////////////////////////////////////////////////////////////////////////

module risc_core_decode_stack
  import risc_core_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int STACK_DEPTH = `STACK_DEPTH
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic [15:0] src_reg_data,
  input wire logic int_request,
  input wire logic [15:0] int_vector,
  input wire logic watchdog_reset,
  input wire logic [15:0] pw_attempt,
  input wire logic pw_attempt_valid,
  input wire logic [15:0] pw_stored,
  input wire logic flash_write_req,
  input wire logic mass_erase_req,
  input wire logic lock_set_req,
  input wire logic exec_from_data,
  input wire logic const_from_prog,
  output logic [ADDR_W-1:0] prog_addr,
  output logic prog_in_rom,
  output logic prog_in_data,
  output logic [3:0] src_module,
  output logic [3:0] src_index,
  output logic src_is_imm,
  output logic [3:0] dst_module,
  output logic [7:0] dst_index,
  output logic dst_write,
  output logic [15:0] move_data,
  output logic [15:0] acc_value,
  output logic [15:0] dp0,
  output logic [15:0] dp1,
  output logic [15:0] dp2,
  output logic data_from_prog,
  output logic [3:0] stack_index,
  output logic [15:0] stack_top,
  output logic password_lock_bit,
  output logic flash_write_grant,
  output logic flash_write_refused,
  output logic [3:0] pw_word_addr,
  output logic pw_erase_fill
);

////////////////////////////////////////////////////////////////////////////////
// field split of the current word

  logic fmt;
  logic [7:0] src_field;
  logic [3:0] d_mod;
  logic [2:0] d_sub;
  logic [15:0] src_value;
  assign fmt = instr[`FMT_BIT];
  assign src_field = instr[`SRC_MSB:`SRC_LSB];
  assign d_mod = instr[`DST_LSB+`DST_MOD_W-1:`DST_LSB];
  assign d_sub = instr[`DST_MSB:`DST_MSB-`DST_SUB_W+1];
  // register source comes back from the selected module the same cycle
  assign src_value = fmt ? src_reg_data : {8'h00, src_field};

  logic go;
  assign go = clk_en & instr_valid;

////////////////////////////////////////////////////////////////////////////////
// decode, prefix, accumulators, pointers, program counter

  logic [`PFX_W-1:0] destination_prefix_reg;
  logic [`PFX_W-1:0] next_destination_prefix_reg;
  logic [3:0] acc_sel;
  logic [3:0] next_acc_sel;
  logic [15:0] acc [`NUM_ACC];
  logic [15:0] next_acc_word;
  logic acc_wr;
  logic [15:0] dp [`NUM_DP];
  logic [15:0] next_dp [`NUM_DP];
  dp_mode_type dp_mode [`NUM_DP];
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [3:0] next_src_module;
  logic [3:0] next_src_index;
  logic [3:0] next_dst_module;
  logic [7:0] next_dst_index;
  logic next_dst_write;
  logic [15:0] next_move_data;
  stack_op_type sop;
  logic [15:0] spush_val;
  logic [3:0] sidx;
  logic [15:0] stack_mem [STACK_DEPTH];

  // prefix-extended destination select
  logic [7:0] full_dst;
  assign full_dst = {destination_prefix_reg, d_sub};

  always_comb
  begin
    next_destination_prefix_reg = destination_prefix_reg;
    next_acc_sel = acc_sel;
    next_acc_word = acc[acc_sel];
    acc_wr = 1'b0;
    next_pc = pc;
    next_src_module = src_module;
    next_src_index = src_index;
    next_dst_module = dst_module;
    next_dst_index = dst_index;
    next_dst_write = 1'b0;
    next_move_data = move_data;
    sop = op_none;
    spush_val = 16'h0000;
    for (int i = 0; i < `NUM_DP; i++)
    begin
      dp_mode[i] = dp_hold;
    end
    if (int_request && clk_en)
    begin
      sop = op_intr;
      spush_val = pc;
      next_pc = int_vector;
    end
    else if (go)
    begin
      // every word executes fully in this one edge
      next_pc = pc + 16'h0001;
      next_src_module = src_field[3:0];
      next_src_index = src_field[7:4];
      next_dst_module = d_mod;
      next_dst_index = full_dst;
      next_move_data = src_value;
      next_destination_prefix_reg = '0; // prefix lives one word only
      if (d_mod == `MOD_PFX && d_sub == 3'h0)
      begin
        // the extra cycle costs no destination write of its own
        next_destination_prefix_reg = src_value[`PFX_W-1:0];
      end
      else
      begin
        next_dst_write = 1'b1;
        case (d_mod)
          `MOD_IMM_ACC:
          begin
            // accumulator select: index by the low four bits of the source value
            next_acc_sel = src_value[3:0];
          end
          `MOD_ACC:
          begin
            acc_wr = 1'b1;
            case (d_sub)
              3'h1: next_acc_word = acc[acc_sel] + src_value;
              3'h2: next_acc_word = acc[acc_sel] - src_value;
              3'h3: next_acc_word = acc[acc_sel] & src_value;
              3'h4: next_acc_word = acc[acc_sel] | src_value;
              3'h5: next_acc_word = acc[acc_sel] ^ src_value;
              default: next_acc_word = src_value;
            endcase
          end
          `MOD_PC:
          begin
            case (d_sub)
              3'h0: next_pc = src_value; // jump
              3'h1:
              begin
                sop = op_call;
                spush_val = pc + 16'h0001;
                next_pc = src_value;
              end
              3'h2:
              begin
                sop = op_ret;
                next_pc = stack_mem[sidx];
              end
              3'h3:
              begin
                sop = op_return_from_interrupt;
                next_pc = stack_mem[sidx];
              end
              default: next_pc = pc + 16'h0001;
            endcase
          end
          `MOD_SP:
          begin
            case (d_sub)
              3'h0:
              begin
                sop = op_push;
                spush_val = src_value;
              end
              3'h1: sop = op_pop;
              3'h2: sop = op_pop_with_interrupt_enable;
              default: sop = op_none;
            endcase
          end
          `MOD_DP:
          begin
            // subindex bits 1:0 pick the pointer; source bit 0 picks direction (1 steps down)
            if (d_sub[2] == 1'b0 && d_sub[1:0] != 2'h3)
            begin
              dp_mode[d_sub[1:0]] = src_value[0] ? dp_dec : dp_inc;
            end
          end
          default: next_dst_write = 1'b1;
        endcase
      end
    end
    for (int i = 0; i < `NUM_DP; i++)
    begin
      case (dp_mode[i])
        dp_inc: next_dp[i] = dp[i] + 16'h0001;
        dp_dec: next_dp[i] = dp[i] - 16'h0001;
        default: next_dp[i] = dp[i];
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      destination_prefix_reg <= '0;
      acc_sel <= 4'h0;
      pc <= `ROM_BASE;
      src_module <= 4'h0;
      src_index <= 4'h0;
      dst_module <= 4'h0;
      dst_index <= 8'h00;
      dst_write <= 1'b0;
      move_data <= 16'h0000;
      for (int i = 0; i < `NUM_ACC; i++)
      begin
        acc[i] <= 16'h0000;
      end
      for (int i = 0; i < `NUM_DP; i++)
      begin
        dp[i] <= 16'h0000;
      end
    end
    else if (watchdog_reset)
    begin
      pc <= `ROM_BASE;
      destination_prefix_reg <= '0;
      dst_write <= 1'b0;
    end
    else if (clk_en)
    begin
      destination_prefix_reg <= next_destination_prefix_reg;
      acc_sel <= next_acc_sel;
      pc <= next_pc;
      src_module <= next_src_module;
      src_index <= next_src_index;
      dst_module <= next_dst_module;
      dst_index <= next_dst_index;
      dst_write <= next_dst_write;
      move_data <= next_move_data;
      if (acc_wr)
      begin
        acc[acc_sel] <= next_acc_word;
      end
      for (int i = 0; i < `NUM_DP; i++)
      begin
        dp[i] <= next_dp[i];
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// memory map outputs

  logic next_prog_in_rom;
  assign next_prog_in_rom = (next_pc >= `ROM_BASE) &&
    (next_pc < `ROM_BASE + 16'(`ROM_WORDS));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_addr <= ADDR_W'(`ROM_BASE);
      prog_in_rom <= 1'b1;
      prog_in_data <= 1'b0;
      data_from_prog <= 1'b0;
      src_is_imm <= 1'b0;
      acc_value <= 16'h0000;
      dp0 <= 16'h0000;
      dp1 <= 16'h0000;
      dp2 <= 16'h0000;
    end
    else if (watchdog_reset)
    begin
      prog_addr <= ADDR_W'(`ROM_BASE);
      prog_in_rom <= 1'b1;
      prog_in_data <= 1'b0;
    end
    else if (clk_en)
    begin
      prog_addr <= ADDR_W'(next_pc);
      prog_in_rom <= next_prog_in_rom;
      prog_in_data <= exec_from_data;
      data_from_prog <= const_from_prog;
      src_is_imm <= go ? ~fmt : src_is_imm;
      acc_value <= acc_wr ? next_acc_word : acc[next_acc_sel];
      dp0 <= next_dp[0];
      dp1 <= next_dp[1];
      dp2 <= next_dp[2];
    end
  end

////////////////////////////////////////////////////////////////////////////////
// hardware stack

  logic [3:0] next_sidx;
  always_comb
  begin
    next_sidx = sidx;
    case (sop)
      op_push, op_call, op_intr: next_sidx = sidx + 4'h1;
      op_pop, op_ret, op_return_from_interrupt, op_pop_with_interrupt_enable: next_sidx = sidx - 4'h1;
      default: next_sidx = sidx;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sidx <= `STACK_RESET;
      stack_index <= `STACK_RESET;
      stack_top <= 16'h0000;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stack_mem[i] <= 16'h0000;
      end
    end
    else if (clk_en && !watchdog_reset)
    begin
      sidx <= next_sidx;
      stack_index <= next_sidx;
      if (sop == op_push || sop == op_call || sop == op_intr)
      begin
        stack_mem[next_sidx] <= spush_val;
      end
      // pops read the old entry before the index moves
      if (sop == op_pop || sop == op_pop_with_interrupt_enable)
      begin
        stack_top <= stack_mem[sidx];
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// password lock and flash guard

  lock_state_type lock_state;
  lock_state_type next_lock_state;
  logic [3:0] next_pw_word_addr;
  logic pw_ok;
  logic next_pw_ok;
  logic next_lock;
  logic next_grant;
  logic next_refused;
  logic next_fill;

  always_comb
  begin
    next_lock_state = lock_state;
    next_pw_word_addr = pw_word_addr;
    next_pw_ok = pw_ok;
    next_lock = password_lock_bit;
    next_grant = 1'b0;
    next_refused = 1'b0;
    next_fill = 1'b0;
    case (lock_state)
      lock_idle:
      begin
        if (pw_attempt_valid)
        begin
          next_lock_state = lock_compare;
          // word 0 at 0010h is taken now, so the walk goes on at 1
          next_pw_word_addr = 4'h1;
          next_pw_ok = (pw_attempt == pw_stored);
        end
      end
      lock_compare:
      begin
        if (pw_attempt_valid)
        begin
          next_pw_ok = pw_ok & (pw_attempt == pw_stored);
          next_pw_word_addr = pw_word_addr + 4'h1;
          if (pw_word_addr == 4'(`PW_WORDS - 1))
          begin
            next_lock_state = lock_done;
          end
        end
      end
      lock_done: next_lock_state = lock_done;
      default: next_lock_state = lock_idle;
    endcase
    // unprogrammed parts accept updates without the key
    if (flash_write_req)
    begin
      if (!password_lock_bit || (lock_state == lock_done && pw_ok))
      begin
        next_grant = 1'b1;
      end
      else
      begin
        next_refused = 1'b1;
      end
    end
    if (mass_erase_req)
    begin
      next_fill = 1'b1;
      next_lock = 1'b0;
      next_pw_ok = 1'b0;
      next_lock_state = lock_idle;
      // a key cut short by the erase must not shift the next one
      next_pw_word_addr = 4'h0;
    end
    else if (lock_set_req)
    begin
      next_lock = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_state <= lock_idle;
      pw_word_addr <= 4'h0;
      pw_ok <= 1'b0;
      password_lock_bit <= 1'b0;
      flash_write_grant <= 1'b0;
      flash_write_refused <= 1'b0;
      pw_erase_fill <= 1'b0;
    end
    else if (clk_en)
    begin
      lock_state <= next_lock_state;
      pw_word_addr <= next_pw_word_addr;
      pw_ok <= next_pw_ok;
      password_lock_bit <= next_lock;
      flash_write_grant <= next_grant;
      flash_write_refused <= next_refused;
      pw_erase_fill <= next_fill;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// checks

  chk_stack_push_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !watchdog_reset && sop == op_push |=> sidx == $past(sidx) + 4'h1)
    else $error("push did not advance stack index");
  chk_stack_pop_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !watchdog_reset && sop == op_pop
    |=> stack_top == $past(stack_mem[sidx]) && sidx == $past(sidx) - 4'h1)
    else $error("pop order wrong");
  chk_wdog_rom_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    watchdog_reset |=> prog_addr == ADDR_W'(`ROM_BASE) && prog_in_rom)
    else $error("watchdog did not restart at rom");
  chk_refuse_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && flash_write_req && password_lock_bit && !pw_ok && !mass_erase_req
    |=> flash_write_refused && !flash_write_grant)
    else $error("locked flash write not refused");
  chk_prefix_one_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    go && !int_request && !watchdog_reset && d_mod == `MOD_PFX && d_sub == 3'h0
    |=> !dst_write)
    else $error("prefix write produced a destination write");
  chk_src_split: assert property (@(posedge sys_clk) disable iff (!rst_n)
    go && !int_request && !watchdog_reset
    |=> src_module == $past(instr[3:0]) && src_index == $past(instr[7:4]))
    else $error("source field split wrong");
  chk_imm_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
    go && !int_request && !watchdog_reset && !fmt
    |=> move_data == {8'h00, $past(instr[7:0])})
    else $error("immediate source wrong");
  chk_erase_unlock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && mass_erase_req |=> pw_erase_fill && !password_lock_bit)
    else $error("mass erase did not clear lock");

endmodule
`default_nettype wire

// *** logic/risc_core_pkg.sv ***
// types shared by the core decode and stack logic
package risc_core_pkg;
  typedef enum logic [2:0] {
    op_none, op_push, op_pop, op_call, op_ret, op_return_from_interrupt, op_pop_with_interrupt_enable, op_intr
  } stack_op_type;
  typedef enum logic [1:0] {
    dp_hold, dp_inc, dp_dec
  } dp_mode_type;
  typedef enum logic [1:0] {
    lock_idle, lock_compare, lock_done
  } lock_state_type;
endpackage
